// ==== inc/nam_pkg.sv ====
// Package: NAND host address sequencer constants and types
package nam_pkg;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int COL_W = 12;
  localparam int ROW_W = 17;
  localparam int PIB_W = 6;
  localparam int BLK_W = 11;
  localparam logic [COL_W-1:0] PAGE_BYTES = 12'h880;
  localparam logic [COL_W-1:0] MAIN_BYTES = 12'h800;
  localparam logic [COL_W-1:0] SPARE_BYTES = 12'h080;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int NUM_BLOCKS = 2048;
  localparam int MIN_VALID_BLOCKS = 2008;
  localparam logic [BLK_W-1:0] SAFE_BLOCK = 11'h000;
  localparam int ADDR_CYCLES = 5;
  // ----------------------------------------------------------------
  // Strobe timing (10 MHz, 100 ns period)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WH_CYC = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (WP_CYC < 1) ? 1 : WP_CYC;
  localparam int HIGH_CYC = (WH_CYC < 1) ? 1 : WH_CYC;
  localparam int CNT_W = 4;
  // ----------------------------------------------------------------
  // Byte kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NAM_KIND_CMD,
    NAM_KIND_ADDR,
    NAM_KIND_DATA
  } nam_kind_t;
  typedef enum logic [1:0] {
    NAM_IDLE,
    NAM_LOW,
    NAM_HIGH
  } nam_state_t;
endpackage : nam_pkg

// ==== design/nam_addr_pack.sv ====
// Packs linear column and page indices into five address bytes
`timescale 1ns/1ps
module nam_addr_pack
  import nam_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [COL_W-1:0] column_index,
  input wire logic [ROW_W-1:0] row_page_index,
  input wire logic [2:0] sel,
  output logic [7:0] byte_out,
  output logic [PIB_W-1:0] page_in_block,
  output logic [BLK_W-1:0] block_index
);
  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
  } nam_pack_st_t;
  nam_pack_st_t st_r, st_nxt;

  // ----------------------------------------------------------------
  // Byte selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] nam_addr_byte(input logic [COL_W-1:0] c, input logic [ROW_W-1:0] r,
                                               input logic [2:0] i);
    unique case (i)
      3'h0: nam_addr_byte = c[7:0];
      3'h1: nam_addr_byte = {4'h0, c[11:8]};
      3'h2: nam_addr_byte = r[7:0];
      3'h3: nam_addr_byte = r[15:8];
      3'h4: nam_addr_byte = {7'h00, r[16]};
      default: nam_addr_byte = 8'h00;
    endcase
  endfunction : nam_addr_byte

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.col = column_index;
      st_nxt.row = row_page_index;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign byte_out = nam_addr_byte(st_r.col, st_r.row, sel);
  assign page_in_block = st_r.row[PIB_W-1:0];
  assign block_index = st_r.row[ROW_W-1:PIB_W];
endmodule : nam_addr_pack

// ==== design/nam_host_seq.sv ====
// Host sequencer driving NAND command, address and data bytes
`timescale 1ns/1ps
// Behaviour
// - Address goes out as five bytes
// - One shared eight-bit port for everything
// - Tolerate bad blocks, 2008 minimum valid
// - Expect fewer valid blocks with two-plane
// - Latch levels mark command or address
module nam_host_seq
  import nam_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire nam_kind_t req_kind,
  input wire logic [7:0] req_byte,
  input wire logic [COL_W-1:0] column_index,
  input wire logic [ROW_W-1:0] row_page_index,
  input wire logic block_bad,
  output logic req_ready,
  output logic req_reject,
  output logic done,
  output logic chip_enable_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic [PIB_W-1:0] page_in_block,
  output logic [BLK_W-1:0] block_index,
  output logic spare_area
);
  typedef struct packed {
    nam_state_t state;
    nam_kind_t kind;
    logic [2:0] idx;
    logic [CNT_W-1:0] cnt;
    logic [7:0] data;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic oe;
    logic done;
    logic rej;
    logic spare;
  } nam_seq_st_t;
  nam_seq_st_t st_r, st_nxt;
  logic [7:0] addr_byte;
  logic load;
  // Cycles from the taking edge to the edge that samples done after an address
  localparam int ADDR_DONE_DLY = ADDR_CYCLES * (STROBE_CYC + HIGH_CYC) + 1;

  // ----------------------------------------------------------------
  // Address packing
  // ----------------------------------------------------------------
  nam_addr_pack u_pack (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(load),
    .column_index(column_index),
    .row_page_index(row_page_index),
    .sel(st_r.idx + 3'h1),
    .byte_out(addr_byte),
    .page_in_block(page_in_block),
    .block_index(block_index)
  );

  // Block zero is never refused; other flagged blocks are, since bad blocks occur
  function automatic logic nam_refuse(input logic bad, input logic [ROW_W-1:0] r);
    nam_refuse = bad && (r[ROW_W-1:PIB_W] != SAFE_BLOCK);
  endfunction : nam_refuse

  assign load = (st_r.state == NAM_IDLE) && req_valid && (req_kind == NAM_KIND_ADDR);
  assign req_ready = (st_r.state == NAM_IDLE);

  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.rej = 1'b0;
    unique case (st_r.state)
      NAM_IDLE: begin
        st_nxt.ce_n = 1'b1;
        st_nxt.oe = 1'b0;
        st_nxt.cle = 1'b0;
        st_nxt.ale = 1'b0;
        st_nxt.idx = 3'h0;
        if (req_valid) begin
          if (req_kind == NAM_KIND_ADDR && nam_refuse(block_bad, row_page_index)) begin
            st_nxt.rej = 1'b1;
          end else begin
            st_nxt.kind = req_kind;
            st_nxt.ce_n = 1'b0;
            st_nxt.cle = (req_kind == NAM_KIND_CMD);
            st_nxt.ale = (req_kind == NAM_KIND_ADDR);
            st_nxt.oe = 1'b1;
            st_nxt.we_n = 1'b0;
            st_nxt.cnt = CNT_W'(STROBE_CYC);
            st_nxt.state = NAM_LOW;
            // Columns past the main area but below PAGE_BYTES select the spare region
            st_nxt.spare = (column_index >= MAIN_BYTES) && (column_index < PAGE_BYTES);
            // First address byte comes straight from the inputs; the packer loads on this edge
            st_nxt.data = (req_kind == NAM_KIND_ADDR) ? column_index[7:0] : req_byte;
          end
        end
      end
      NAM_LOW: begin
        st_nxt.cnt = st_r.cnt - CNT_W'(1);
        if (st_r.cnt == CNT_W'(1)) begin
          st_nxt.we_n = 1'b1;
          st_nxt.cnt = CNT_W'(HIGH_CYC);
          st_nxt.state = NAM_HIGH;
        end
      end
      NAM_HIGH: begin
        st_nxt.cnt = st_r.cnt - CNT_W'(1);
        if (st_r.cnt == CNT_W'(1)) begin
          if (st_r.kind == NAM_KIND_ADDR && st_r.idx != 3'(ADDR_CYCLES - 1)) begin
            st_nxt.idx = st_r.idx + 3'h1;
            st_nxt.data = addr_byte;
            st_nxt.we_n = 1'b0;
            st_nxt.cnt = CNT_W'(STROBE_CYC);
            st_nxt.state = NAM_LOW;
          end else begin
            // Device then runs program or erase on its own; no further strobes
            st_nxt.done = 1'b1;
            st_nxt.state = NAM_IDLE;
          end
        end
      end
      default: st_nxt.state = NAM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= '{state: NAM_IDLE, kind: NAM_KIND_CMD, idx: 3'h0, cnt: '0, data: 8'h00,
                ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, oe: 1'b0, done: 1'b0,
                rej: 1'b0, spare: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chip_enable_n = st_r.ce_n;
  assign cmd_latch = st_r.cle;
  assign addr_latch = st_r.ale;
  assign write_strobe_n = st_r.we_n;
  assign io_out = st_r.data;
  assign io_oe = st_r.oe;
  assign done = st_r.done;
  assign req_reject = st_r.rej;
  assign spare_area = st_r.spare;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_latch_excl;
    @(posedge ref_clk) disable iff (reset) !(cmd_latch && addr_latch);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  property p_strobe_ce;
    @(posedge ref_clk) disable iff (reset) !write_strobe_n |-> !chip_enable_n && io_oe;
  endproperty
  a_strobe_ce: assert property (p_strobe_ce) else $error("strobe without chip enable");
  property p_byte2_hi;
    @(posedge ref_clk) disable iff (reset) (addr_latch && st_r.idx == 3'h1) |-> io_out[7:4] == 4'h0;
  endproperty
  a_byte2_hi: assert property (p_byte2_hi) else $error("byte 2 high bits set");
  property p_byte5_hi;
    @(posedge ref_clk) disable iff (reset) (addr_latch && st_r.idx == 3'h4) |-> io_out[7:1] == 7'h00;
  endproperty
  a_byte5_hi: assert property (p_byte5_hi) else $error("byte 5 high bits set");
  property p_addr_len;
    @(posedge ref_clk) disable iff (reset)
      (req_ready && req_valid && req_kind == NAM_KIND_ADDR && !nam_refuse(block_bad, row_page_index))
      |-> ##ADDR_DONE_DLY (done && $past(st_r.idx) == 3'h4);
  endproperty
  a_addr_len: assert property (p_addr_len) else $error("address not five bytes");
  property p_blk0;
    @(posedge ref_clk) disable iff (reset)
      (req_ready && req_valid && row_page_index[ROW_W-1:PIB_W] == SAFE_BLOCK) |=> !req_reject;
  endproperty
  a_blk0: assert property (p_blk0) else $error("block zero refused");
  property p_split;
    @(posedge ref_clk) disable iff (reset)
      load |=> (page_in_block == $past(row_page_index[PIB_W-1:0]))
               && (block_index == $past(row_page_index[ROW_W-1:PIB_W]));
  endproperty
  a_split: assert property (p_split) else $error("split mismatch");
  property p_cmd_one;
    @(posedge ref_clk) disable iff (reset) $rose(cmd_latch) |-> cmd_latch [*2] ##1 1'b1;
  endproperty
  a_cmd_one: assert property (p_cmd_one) else $error("command strobe too short");
  c_addr: cover property (@(posedge ref_clk) disable iff (reset) addr_latch && st_r.idx == 3'h4);
  c_cmd: cover property (@(posedge ref_clk) disable iff (reset) cmd_latch && !write_strobe_n);
  c_rej: cover property (@(posedge ref_clk) disable iff (reset) req_reject);
endmodule : nam_host_seq

// ==== dv/nam_flash_model.sv ====
// Behavioural NAND device that captures command, address and data bytes
`timescale 1ns/1ps
module nam_flash_model
  import nam_pkg::*;
(
  input wire logic chip_enable_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic [7:0] io_bus,
  output logic ready_busy_flag
);
  // ----------------------------------------------------------------
  // Byte capture on the rising write strobe
  // ----------------------------------------------------------------
  logic [7:0] last_cmd;
  logic [7:0] last_data;
  logic [7:0] addr_q[$];
  logic [7:0] page_reg [2176];
  int n_strobe = 0;
  int data_ptr = 0;
  // Never busy: array work is not modelled, only the byte traffic
  assign ready_busy_flag = 1'b1;
  // A new address frame starts with each rise of the address latch
  always @(posedge addr_latch) addr_q.delete();
  always @(posedge write_strobe_n) begin
    if (!chip_enable_n) begin
      n_strobe++;
      if (cmd_latch && !addr_latch) begin
        last_cmd = io_bus;
        data_ptr = 0;
      end
      else if (addr_latch && !cmd_latch) begin
        addr_q.push_back(io_bus);
      end
      else begin
        last_data = io_bus;
        page_reg[data_ptr] = io_bus;
        data_ptr = (data_ptr + 1) % 2176;
      end
    end
  end
endmodule : nam_flash_model

// ==== dv/nam_host_seq_bench.sv ====
// Self-checking bench for the NAND host address sequencer
`timescale 1ns/1ps
module nam_host_seq_bench;
  import nam_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, wiring and checking helpers
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  nam_kind_t req_kind = NAM_KIND_CMD;
  logic [7:0] req_byte = 8'h00;
  logic [COL_W-1:0] column_index = '0;
  logic [ROW_W-1:0] row_page_index = '0;
  logic block_bad = 1'b0;
  logic req_ready, req_reject, done, chip_enable_n, cmd_latch, addr_latch, write_strobe_n, io_oe, spare_area;
  logic [7:0] io_out;
  logic [7:0] io_last = 8'h00;
  wire [7:0] io_bus;
  logic [PIB_W-1:0] page_in_block;
  logic [BLK_W-1:0] block_index;
  int fail_count = 0;
  int n_tests = 0;
  int lat;
  logic rej;
  int cb[4] = '{0, 2047, 2048, 2175};
  int rb[4] = '{0, 131071, 64, 63};
  int e[5];
  int col, row, s0;
  logic [7:0] b;
  always #50 ref_clk = ~ref_clk;
  // Undriven port shows the inverse of its last value, never a stale copy
  always @(posedge ref_clk) if (io_oe) io_last <= io_out;
  assign io_bus = io_oe ? io_out : ~io_last;
  nam_host_seq dut (.ref_clk, .reset, .req_valid, .req_kind, .req_byte, .column_index, .row_page_index,
    .block_bad, .req_ready, .req_reject, .done, .chip_enable_n, .cmd_latch, .addr_latch, .write_strobe_n,
    .io_out, .io_oe, .page_in_block, .block_index, .spare_area);
  nam_flash_model dev (.chip_enable_n, .cmd_latch, .addr_latch, .write_strobe_n, .io_bus,
    .ready_busy_flag());
  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // Called at posedge+1 while idle; returns latency in lat and refusal in rej
  task automatic send(nam_kind_t k, logic [7:0] bv, int c, int r, logic bad);
    chk("req_ready idle", req_ready, 1'b1);
    req_kind = k;
    req_byte = bv;
    column_index = c[COL_W-1:0];
    row_page_index = r[ROW_W-1:0];
    block_bad = bad;
    req_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    lat = 0;
    while (done !== 1'b1 && req_reject !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      lat++;
      if (lat > 30) begin
        chk("completion wait", 0, 1);
        final_report();
      end
    end
    rej = req_reject;
  endtask : send
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h2436));
    repeat (20) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      send((i % 2) ? NAM_KIND_DATA : NAM_KIND_CMD, b, 0, 0, 1'b0);
      chk("byte latency", lat, STROBE_CYC + HIGH_CYC);
      chk("byte at device", (i % 2) ? dev.last_data : dev.last_cmd, b);
    end
    $display("test byte_kinds done");
    for (int i = 0; i < 8; i++) begin
      col = (i < 4) ? cb[i] : $urandom_range(2175);
      row = (i < 4) ? rb[i] : $urandom_range(131071);
      e = '{col % 256, col / 256, row % 256, (row / 256) % 256, row / 65536};
      // Address latch may stay high between back-to-back frames, so start each frame empty
      dev.addr_q.delete();
      send(NAM_KIND_ADDR, 8'h00, col, row, i == 0);
      chk("addr latency", lat, ADDR_CYCLES * (STROBE_CYC + HIGH_CYC));
      chk("addr byte count", dev.addr_q.size(), 5);
      for (int j = 0; j < 5; j++) chk("addr byte", dev.addr_q[j], e[j]);
      chk("page_in_block", page_in_block, row % 64);
      chk("block_index", block_index, row / 64);
      chk("spare_area", spare_area, col >= 2048);
    end
    $display("test address_cycles done");
    s0 = dev.n_strobe;
    send(NAM_KIND_ADDR, 8'h00, 5, 64 + $urandom_range(131000), 1'b1);
    chk("reject flag", rej, 1'b1);
    chk("reject latency", lat, 0);
    chk("no strobe on refusal", dev.n_strobe, s0);
    b = 8'($urandom);
    send(NAM_KIND_CMD, b, 0, 0, 1'b0);
    chk("command after refusal", dev.last_cmd, b);
    $display("test bad_block_refusal done");
    final_report();
  end
endmodule : nam_host_seq_bench
